// ==== bench/dbw_host.sv ====
// debug pod model: drives the wire from the host side
`timescale 1ns/10ps
module dbw_host (
   input  wire logic clk_in,
   input  wire logic pin_in,
   output logic      drv_out = 1'b1,
   output logic      oe_out = 1'b0
);
   // ---------------------------------------------------------------
   // bit tasks, every change just after a falling clock edge
   // ---------------------------------------------------------------
   task automatic low(input int n);
      drv_out = 1'b0;
      oe_out = 1'b1;
      repeat (n) @(negedge clk_in);
   endtask
   // brief speedup pulse, then let the pullup hold the wire
   task automatic hi;
      drv_out = 1'b1;
      @(negedge clk_in);
      oe_out = 1'b0;
   endtask
   task automatic send(input logic [7:0] b, input int nb);
      for (int i = 7; i > 7 - nb; i--) begin
         low(b[i] ? 4 : 15);
         hi();
         repeat (b[i] ? 13 : 2) @(negedge clk_in);
      end
   endtask
   task automatic recv(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         low(2);
         oe_out = 1'b0;
         repeat (8) @(negedge clk_in);
         b[i] = pin_in;
         repeat (9) @(negedge clk_in);
      end
   endtask
   task automatic sync_req;
      low(140);
      hi();
   endtask
endmodule

// ==== bench/tb_single_wire_debug_bit_link.sv ====
// self-checking bench for the single-wire debug bit link
`timescale 1ns/10ps
module tb_single_wire_debug_bit_link;
   // ---------------------------------------------------------------
   // clock, wire, design and pod
   // ---------------------------------------------------------------
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        pin, pout, poe, h_drv, h_oe, snd, bgm, ex;
   logic        rx_v, rx_rdy, tx_v, tx_rdy, cv, ok, rf, sd, fb, den, lp;
   logic        bg, wd, wk, rs, osc, ben, hit, tmo, ovr, sb, fetch;
   logic [7:0]  rx_d, tx_d, code, got;
   logic [15:0] baddr, caddr;
   logic [31:0] seed = 32'hb2a5;
   logic [7:0]  q[$];
   logic [7:0]  cl[14] = '{8'h68, 8'he0, 8'h08, 8'h4c, 8'h90, 8'h68, 8'h4c,
                          8'h08, 8'h90, 8'h10, 8'h90, 8'h18, 8'hc4, 8'h70};
   int          failures, checked, n, ovr_n, tmo_n, rs_n, wk_n, hit_n, sd_n;
   int          low_n, oe_n, rs_e, wk_e, sd_e, rdy_n;
   logic        sel = 1'b0, alt = 1'b0;
   always #12.5 clk = ~clk;
   // wired-and of pod, target and pullup
   assign pin = ~((h_oe & ~h_drv) | (poe & ~pout));
   dbw_link u_dut (.ref_clk_in(clk), .rst_in(rst), .pin_in(pin), .pin_out(pout),
      .pin_oe_out(poe), .debug_clock_select_in(sel), .alt_tick_in(alt),
      .rx_data_out(rx_d), .rx_valid_out(rx_v), .rx_ready_in(rx_rdy),
      .tx_data_in(tx_d), .tx_valid_in(tx_v), .tx_ready_out(tx_rdy),
      .cmd_code_in(code), .cmd_valid_in(cv), .cmd_ok_out(ok), .cmd_refused_out(rf),
      .slot_done_out(sd), .force_bg_cmd_in(fb), .debug_enable_in(den),
      .low_power_in(lp), .bg_mode_out(bg), .watchdog_hold_out(wd), .wake_out(wk),
      .resume_out(rs), .osc_keep_out(osc), .bkpt_enable_in(ben),
      .bkpt_addr_in(baddr), .cpu_addr_in(caddr), .cpu_fetch_in(fetch),
      .bkpt_hit_out(hit), .timeout_out(tmo), .overrun_out(ovr), .sync_busy_out(sb));
   dbw_host u_host (.clk_in(clk), .pin_in(pin), .drv_out(h_drv), .oe_out(h_oe));
   // ---------------------------------------------------------------
   // monitors, model helpers and checks
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      ovr_n += (ovr === 1'b1);
      tmo_n += (tmo === 1'b1);
      rs_n += (rs === 1'b1);
      wk_n += (wk === 1'b1);
      hit_n += (hit === 1'b1);
      sd_n += (sd === 1'b1);
      low_n += (poe === 1'b1 && pout === 1'b0);
      oe_n += (poe === 1'b1 && snd === 1'b1);
      rdy_n += (tx_rdy === 1'b1);
      // alternate debug clock at half rate while selected
      alt <= sel & ~alt;
      if (tx_rdy === 1'b1) tx_v <= 1'b0;
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      ex = !(c[7:4] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7}) || bgm;
      code = c;
      cv = 1'b1;
      @(negedge clk);
      cv = 1'b0;
      chk("cmd_ok", ok, ex);
      chk("cmd_refused", rf, !ex);
      sd_e += ex;
      if (ex && c == dbw_pkg::CMD_BACKGROUND) begin
         bgm = 1'b1;
         wk_e++;
      end else if (ex && c inside {dbw_pkg::CMD_GO, dbw_pkg::CMD_TRACE, dbw_pkg::CMD_TAGGO}) begin
         bgm = 1'b0;
         rs_e++;
      end
      repeat (22) @(negedge clk);
      chk("bg_mode", bg, bgm);
   endtask
   task automatic drain;
      logic [7:0] e;
      while (q.size() > 0) begin
         e = q.pop_front();
         for (n = 0; rx_v !== 1'b1 && n < 8; n++) @(negedge clk);
         chk("rx_data", rx_d, e);
         rx_rdy = 1'b1;
         @(negedge clk);
         rx_rdy = 1'b0;
         @(negedge clk);
      end
      chk("rx_empty", rx_v, 1'b0);
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (40000) @(negedge clk);
      failures++;
      conclude();
   end
   initial begin
      {rx_rdy, tx_v, cv, fb, lp, ben, fetch, den, snd, bgm} = '0;
      {tx_d, code, baddr, caddr} = '0;
      u_host.low(0);
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      chk("bg_strap", bg, 1'b1);
      chk("wd_hold", wd, 1'b1);
      u_host.hi();
      rst = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk("bg_strap", bg, 1'b0);
      {den, lp, ben, baddr} = {3'b111, rnd(), rnd()};
      caddr = baddr ^ 16'h0001;
      fetch = 1'b1;
      @(negedge clk);
      caddr = baddr;
      @(negedge clk);
      fetch = 1'b0;
      repeat (2) @(negedge clk);
      chk("osc_keep", osc, 1'b1);
      chk("bkpt_hits", hit_n, 1);
      $display("test reset and misc done");
      foreach (cl[i]) cmd(cl[i]);
      chk("resume", rs_n, rs_e);
      chk("wake", wk_n, wk_e);
      chk("slot_done", sd_n, sd_e);
      $display("test commands done");
      snd = 1'b1;
      for (int i = 0; i < 10; i++) begin
         got = rnd();
         if (i != 8) q.push_back(got);
         u_host.send(got, 8);
      end
      snd = 1'b0;
      chk("overrun", ovr_n, 1);
      chk("target_drive", oe_n, 0);
      drain();
      $display("test receive fill done");
      for (int i = 0; i < 3; i++) begin
         tx_d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
         tx_v = 1'b1;
         u_host.recv(got);
         chk("tx_data", got, tx_d);
      end
      chk("tx_taken", rdy_n, 3);
      $display("test transmit done");
      fb = 1'b1;
      @(negedge clk);
      fb = 1'b0;
      u_host.send(rnd(), 3);
      chk("bg_forced", bg, 1'b1);
      n = tmo_n;
      sel = 1'b1;
      repeat (600) @(negedge clk);
      chk("timeout_slow", tmo_n, n);
      repeat (600) @(negedge clk);
      sel = 1'b0;
      chk("timeout", tmo_n, n + 1);
      chk("bg_kept", bg, 1'b1);
      got = rnd();
      q.push_back(got);
      u_host.send(got, 8);
      drain();
      $display("test force and timeout done");
      n = low_n;
      u_host.sync_req();
      repeat (50) @(negedge clk);
      chk("sync_busy", sb, 1'b1);
      repeat (170) @(negedge clk);
      chk("sync_low", low_n, n + 128);
      chk("sync_idle", sb, 1'b0);
      $display("test sync done");
      conclude();
   end
endmodule

// ==== rtl/dbw_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module dbw_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             ref_clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   output logic      [WIDTH-1:0] out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);

   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0]   count;
   wire              push = in_valid_in & in_ready_out;
   wire              pop  = out_valid_out & out_ready_in;

   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
   endfunction

   assign in_ready_out  = (count != (PTR_W+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign out_data_out  = mem[rd_ptr];

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= bump(wr_ptr);
         if (pop) rd_ptr <= bump(rd_ptr);
         if (push & ~pop) count <= count + 1'b1;
         else if (pop & ~push) count <= count - 1'b1;
      end
   end

endmodule

// ==== rtl/dbw_link.sv ====
// single-wire debug bit link: bit timing, sync, mode entry and command gating
`timescale 1ns/10ps
module dbw_link #(
   parameter int unsigned ADDR_W     = 16,
   parameter int unsigned FIFO_DEPTH = 8
) (
   input  wire logic              ref_clk_in,
   input  wire logic              rst_in,
   input  wire logic              pin_in,
   output logic                   pin_out,
   output logic                   pin_oe_out,
   input  wire logic              debug_clock_select_in,
   input  wire logic              alt_tick_in,
   output logic       [7:0]       rx_data_out,
   output logic                   rx_valid_out,
   input  wire logic              rx_ready_in,
   input  wire logic  [7:0]       tx_data_in,
   input  wire logic              tx_valid_in,
   output logic                   tx_ready_out,
   input  wire logic  [7:0]       cmd_code_in,
   input  wire logic              cmd_valid_in,
   output logic                   cmd_ok_out,
   output logic                   cmd_refused_out,
   output logic                   slot_done_out,
   input  wire logic              force_bg_cmd_in,
   input  wire logic              debug_enable_in,
   input  wire logic              low_power_in,
   output logic                   bg_mode_out,
   output logic                   watchdog_hold_out,
   output logic                   wake_out,
   output logic                   resume_out,
   output logic                   osc_keep_out,
   input  wire logic              bkpt_enable_in,
   input  wire logic  [ADDR_W-1:0] bkpt_addr_in,
   input  wire logic  [ADDR_W-1:0] cpu_addr_in,
   input  wire logic              cpu_fetch_in,
   output logic                   bkpt_hit_out,
   output logic                   timeout_out,
   output logic                   overrun_out,
   output logic                   sync_busy_out
);

   localparam logic [dbw_pkg::CYC_W-1:0] CYC_MAX = '1;

   // ------------------------------------------------------------------
   // edge detection and debug clock rate
   // ------------------------------------------------------------------
   logic                        pin_s;
   logic                        pin_prev;
   logic [dbw_pkg::CYC_W-1:0]   cyc;
   dbw_pkg::dbw_state_type      st;
   logic [2:0]                  bit_idx;
   logic [7:0]                  rx_shift;
   logic [7:0]                  tx_shift;
   logic                        tx_active;
   logic                        hold_valid;
   logic [7:0]                  hold_data;
   logic                        fifo_in_ready;
   logic                        strap_pend;
   logic                        force_arm;
   logic [dbw_pkg::SLOT_W-1:0]  slot_cnt;

   dbw_sync u_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .level_in   (pin_in),
      .level_out  (pin_s)
   );

   // bus clock runs every cycle; the alternate source arrives as an enable
   wire tick      = debug_clock_select_in ? alt_tick_in : 1'b1;
   wire fall      = pin_prev & ~pin_s;
   wire rise      = ~pin_prev & pin_s;
   wire in_sync   = (st == dbw_pkg::ST_SYNC_DLY) | (st == dbw_pkg::ST_SYNC_LOW) |
                    (st == dbw_pkg::ST_SYNC_SPEED);
   // a zero bit's own low drive echoes back as a fall; keep it from restarting
   wire own_bit   = (st == dbw_pkg::ST_BIT) & tx_active;
   wire edge_go   = fall & ~in_sync & ~own_bit;
   wire busy      = (bit_idx != 3'd0) | tx_active | (st == dbw_pkg::ST_BIT);
   wire to_hit    = tick & busy & ~in_sync &
                    (cyc == dbw_pkg::CYC_W'(dbw_pkg::TIMEOUT_CYC - 1));
   wire sample_hit = (st == dbw_pkg::ST_BIT) & tick & ~tx_active &
                     (cyc == dbw_pkg::CYC_W'(dbw_pkg::SAMPLE_CYC));
   wire txend_hit = (st == dbw_pkg::ST_BIT) & tick & tx_active &
                    (cyc == dbw_pkg::CYC_W'(dbw_pkg::TX_END_CYC));
   // host sync low is far longer than any bit low time
   wire sync_hit  = rise & ~in_sync &
                    (cyc >= dbw_pkg::CYC_W'(dbw_pkg::SYNC_LOW_CYC));
   wire byte_done = sample_hit & (bit_idx == 3'd7);
   wire [7:0] rx_next = {rx_shift[6:0], pin_s};
   wire tx_load   = edge_go & (bit_idx == 3'd0) & ~tx_active & tx_valid_in;
   wire tx_last   = txend_hit & (bit_idx == 3'd7);

   // ------------------------------------------------------------------
   // sync response phases
   // ------------------------------------------------------------------
   wire dly_done  = (st == dbw_pkg::ST_SYNC_DLY) & tick &
                    (cyc == dbw_pkg::CYC_W'(dbw_pkg::SYNC_DLY_CYC - 1));
   wire low_done  = (st == dbw_pkg::ST_SYNC_LOW) & tick &
                    (cyc == dbw_pkg::CYC_W'(dbw_pkg::SYNC_RESP_CYC - 1));
   wire spd_done  = (st == dbw_pkg::ST_SYNC_SPEED) & tick;
   wire cyc_clr   = edge_go | sync_hit | dly_done | low_done | spd_done;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_prev <= dbw_pkg::PIN_IDLE_RST;
         cyc      <= '0;
      end else begin
         pin_prev <= pin_s;
         if (cyc_clr) cyc <= '0;
         else if (tick && cyc != CYC_MAX) cyc <= cyc + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) st <= dbw_pkg::ST_IDLE;
      else if (sync_hit) st <= dbw_pkg::ST_SYNC_DLY;
      else if (edge_go) st <= dbw_pkg::ST_BIT;
      else if (to_hit | sample_hit | txend_hit | spd_done) st <= dbw_pkg::ST_IDLE;
      else if (dly_done) st <= dbw_pkg::ST_SYNC_LOW;
      else if (low_done) st <= dbw_pkg::ST_SYNC_SPEED;
   end

   // ------------------------------------------------------------------
   // bit and byte assembly
   // ------------------------------------------------------------------
   // a timeout or a sync leaves only the partial byte behind, nothing else
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bit_idx  <= '0;
         rx_shift <= '0;
      end else begin
         if (to_hit | sync_hit) bit_idx <= '0;
         else if (sample_hit | txend_hit) bit_idx <= bit_idx + 1'b1;
         if (sample_hit) rx_shift <= rx_next;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_active    <= 1'b0;
         tx_shift     <= '0;
         tx_ready_out <= 1'b0;
      end else begin
         tx_ready_out <= tx_load;
         if (tx_load) tx_shift <= tx_data_in;
         else if (txend_hit) tx_shift <= {tx_shift[6:0], 1'b0};
         if (tx_load) tx_active <= 1'b1;
         else if (tx_last | to_hit | sync_hit) tx_active <= 1'b0;
      end
   end

   // a byte waits here while the fifo is full; a second one overwrites it
   wire hold_taken = hold_valid & fifo_in_ready;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         hold_valid  <= 1'b0;
         hold_data   <= '0;
         overrun_out <= 1'b0;
      end else begin
         overrun_out <= byte_done & hold_valid & ~hold_taken;
         if (byte_done) hold_data <= rx_next;
         if (byte_done) hold_valid <= 1'b1;
         else if (hold_taken) hold_valid <= 1'b0;
      end
   end

   dbw_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in    (ref_clk_in),
      .rst_in        (rst_in),
      .in_data_in    (hold_data),
      .in_valid_in   (hold_valid),
      .in_ready_out  (fifo_in_ready),
      .out_data_out  (rx_data_out),
      .out_valid_out (rx_valid_out),
      .out_ready_in  (rx_ready_in)
   );

   // ------------------------------------------------------------------
   // wire drive
   // ------------------------------------------------------------------
   // drive only inside a target bit or the sync answer, so no fight with host
   wire in_tx_bit  = (st == dbw_pkg::ST_BIT) & tx_active;
   wire drive_low  = (in_tx_bit & ~tx_shift[7] &
                      (cyc < dbw_pkg::CYC_W'(dbw_pkg::ZERO_LOW_CYC))) |
                     (st == dbw_pkg::ST_SYNC_LOW);
   wire drive_high = (in_tx_bit & tx_shift[7] &
                      (cyc == dbw_pkg::CYC_W'(dbw_pkg::ONE_PULSE_CYC))) |
                     (in_tx_bit & ~tx_shift[7] &
                      (cyc == dbw_pkg::CYC_W'(dbw_pkg::ZERO_LOW_CYC))) |
                     (st == dbw_pkg::ST_SYNC_SPEED);
   wire next_pin_oe = drive_low | drive_high;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pin_oe_out    <= 1'b0;
         pin_out       <= 1'b0;
         timeout_out   <= 1'b0;
         sync_busy_out <= 1'b0;
      end else begin
         pin_oe_out    <= next_pin_oe;
         pin_out       <= drive_high;
         timeout_out   <= to_hit;
         sync_busy_out <= in_sync | sync_hit;
      end
   end

   // ------------------------------------------------------------------
   // mode control and command gating
   // ------------------------------------------------------------------
   wire active_cmd = dbw_pkg::is_active_cmd(cmd_code_in);
   wire cmd_ok     = cmd_valid_in & (~active_cmd | bg_mode_out);
   wire bg_enter   = (cmd_ok & debug_enable_in & (cmd_code_in == dbw_pkg::CMD_BACKGROUND)) |
                     (force_arm & edge_go);
   wire bg_leave   = cmd_ok & ((cmd_code_in == dbw_pkg::CMD_GO) |
                     (cmd_code_in == dbw_pkg::CMD_TRACE) |
                     (cmd_code_in == dbw_pkg::CMD_TAGGO));
   // strap level is caught on the first clock after reset release
   wire next_bg    = strap_pend ? ~pin_in :
                     bg_enter ? 1'b1 : bg_leave ? 1'b0 : bg_mode_out;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         strap_pend        <= 1'b1;
         bg_mode_out       <= dbw_pkg::BG_RST;
         watchdog_hold_out <= dbw_pkg::BG_RST;
         force_arm         <= 1'b0;
      end else begin
         strap_pend        <= 1'b0;
         bg_mode_out       <= next_bg;
         watchdog_hold_out <= next_bg;
         if (force_bg_cmd_in) force_arm <= 1'b1;
         else if (edge_go | to_hit) force_arm <= 1'b0;
      end
   end

   // link and command path run whether or not the cpu is halted
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cmd_ok_out      <= 1'b0;
         cmd_refused_out <= 1'b0;
         wake_out        <= 1'b0;
         resume_out      <= 1'b0;
         osc_keep_out    <= 1'b0;
         bkpt_hit_out    <= 1'b0;
      end else begin
         cmd_ok_out      <= cmd_ok;
         cmd_refused_out <= cmd_valid_in & ~cmd_ok;
         wake_out        <= bg_enter & low_power_in;
         resume_out      <= bg_leave & ~bg_enter;
         osc_keep_out    <= debug_enable_in;
         bkpt_hit_out    <= bkpt_enable_in & cpu_fetch_in &
                            (cpu_addr_in == bkpt_addr_in);
      end
   end

   // delay slot measured in debug cycles so it tracks the selected source
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         slot_cnt      <= '0;
         slot_done_out <= 1'b0;
      end else begin
         slot_done_out <= tick & (slot_cnt == dbw_pkg::SLOT_W'(1));
         if (cmd_ok) slot_cnt <= dbw_pkg::SLOT_W'(dbw_pkg::DELAY_SLOT_CYC);
         else if (tick && slot_cnt != '0) slot_cnt <= slot_cnt - 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   timeout_abort_a: assert property (to_hit |=> (bit_idx == 3'd0) && !tx_active &&
                                     (st == dbw_pkg::ST_IDLE) && timeout_out)
      else $error("timeout did not abort the transfer");
   rx_quiet_a: assert property ((st == dbw_pkg::ST_BIT) && !tx_active |=> !pin_oe_out)
      else $error("wire driven during host bit");
   sample_point_a: assert property ($changed(rx_shift) |->
                                    $past(cyc) == 10 && !$past(tx_active))
      else $error("host bit sampled at wrong count");
   zero_low_a: assert property (in_tx_bit && !tx_shift[7] && cyc < 13 |=>
                                pin_oe_out && !pin_out)
      else $error("zero bit not held low");
   one_pulse_a: assert property (in_tx_bit && tx_shift[7] && cyc != 7 |=> !pin_oe_out)
      else $error("one bit drove outside speedup slot");
   strap_mode_a: assert property ($fell(strap_pend) |-> bg_mode_out == !$past(pin_in))
      else $error("reset strap not taken");
   cmd_refuse_a: assert property (cmd_valid_in && active_cmd && !bg_mode_out |=>
                                  cmd_refused_out && !cmd_ok_out)
      else $error("halted-only command accepted while running");
   watchdog_hold_a: assert property (watchdog_hold_out == bg_mode_out)
      else $error("watchdog hold differs from mode");
   wake_pulse_a: assert property (bg_enter && low_power_in |=> wake_out && bg_mode_out)
      else $error("background request did not wake");
   sync_answer_a: assert property (sync_hit && !debug_clock_select_in |->
                                   ##[17:19] (pin_oe_out && !pin_out))
      else $error("sync answer late");

   byte_rx_c: cover property (byte_done);
   byte_tx_c: cover property (tx_last);
   sync_seen_c: cover property (sync_hit);
   force_bg_c: cover property (force_arm && edge_go);
   timeout_c: cover property (to_hit);

endmodule

// ==== rtl/dbw_pkg.sv ====
// constants and types shared by the single-wire debug bit link
package dbw_pkg;

   // ------------------------------------------------------------------
   // bit timing, in debug clock cycles
   // ------------------------------------------------------------------
   localparam int unsigned BIT_CYC        = 16;
   localparam int unsigned TIMEOUT_CYC    = 512;
   localparam int unsigned SAMPLE_CYC     = 10;
   localparam int unsigned ONE_PULSE_CYC  = 7;
   localparam int unsigned ZERO_LOW_CYC   = 13;
   localparam int unsigned TX_END_CYC     = ZERO_LOW_CYC + 1;
   localparam int unsigned DELAY_SLOT_CYC = 16;

   // ------------------------------------------------------------------
   // sync request and response, in debug clock cycles
   // ------------------------------------------------------------------
   localparam int unsigned SYNC_LOW_CYC  = 128;
   localparam int unsigned SYNC_DLY_CYC  = 16;
   localparam int unsigned SYNC_RESP_CYC = 128;

   // ------------------------------------------------------------------
   // counter widths and reset values
   // ------------------------------------------------------------------
   localparam int unsigned CYC_W        = 10;
   localparam int unsigned SLOT_W       = 5;
   localparam logic        PIN_IDLE_RST = 1'b1;
   localparam logic        BG_RST       = 1'b0;

   // ------------------------------------------------------------------
   // command codes the link acts on
   // ------------------------------------------------------------------
   localparam logic [7:0] CMD_BACKGROUND = 8'h90;
   localparam logic [7:0] CMD_GO         = 8'h08;
   localparam logic [7:0] CMD_TRACE      = 8'h10;
   localparam logic [7:0] CMD_TAGGO      = 8'h18;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_BIT,
      ST_SYNC_DLY,
      ST_SYNC_LOW,
      ST_SYNC_SPEED
   } dbw_state_type;

   // commands that only run while the cpu is halted in background
   function automatic logic is_active_cmd(input logic [7:0] code);
      logic r;
      r = 1'b0;
      unique case (code[7:4])
         4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

endpackage

// ==== rtl/dbw_sync.sv ====
// two-stage synchroniser for the debug wire level
`timescale 1ns/10ps
module dbw_sync (
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   input  wire logic level_in,
   output logic      level_out
);

   logic stage1;

   // stage1 feeds only the second flop
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage1    <= dbw_pkg::PIN_IDLE_RST;
         level_out <= dbw_pkg::PIN_IDLE_RST;
      end else begin
         stage1    <= level_in;
         level_out <= stage1;
      end
   end

endmodule
